// ===== core/tcc_thermostat.sv
`include "tcc_defs.svh"
module tcc_thermostat #(
  parameter int CYC_PER_SEC = `TCC_CYC_PER_SEC,
  parameter int SEC_PER_MIN = `TCC_SEC_PER_MIN
) (
  input  wire logic                  REF_CLK,
  input  wire logic                  RST,
  input  wire logic signed [15:0]    PROBE_RAW,
  input  wire logic                  PROBE_FAULT,
  input  wire logic                  PARAM_WE,
  input  wire logic [4:0]            PARAM_IDX,
  input  wire logic [15:0]           PARAM_WDATA,
  input  wire logic                  BASIC_SET_WE,
  input  wire logic signed [15:0]    BASIC_SET_DATA,
  input  wire logic [7:0]            PASSCODE_ENTRY,
  input  wire logic                  CARD_PRESENT,
  input  wire logic                  CARD_UPLOAD,
  input  wire logic                  CARD_ERASE,
  output tcc_pkg::tcc_card_req_t     CARD_REQ,
  output logic                       CARD_REQ_VALID,
  input  wire logic                  CARD_REQ_READY,
  input  wire tcc_pkg::tcc_card_rsp_t CARD_RSP,
  input  wire logic                  CARD_RSP_VALID,
  output logic                       CARD_RSP_READY,
  output logic                       RELAY_OUT,
  output logic                       USER_ACCESS_OK,
  output logic signed [15:0]         TEMP_CORRECTED,
  output logic                       SHOW_DECIMAL,
  output logic                       SHOW_FAHRENHEIT,
  output logic [1:0]                 PROBE_TYPE,
  output logic [2:0]                 CARD_SHOW,
  output logic                       CARD_BUSY
);
  if (CYC_PER_SEC < 1 || SEC_PER_MIN < 1 || SEC_PER_MIN > 256) begin : g_bad_timebase
    $error("tcc_thermostat: timebase out of range");
  end

  logic [15:0] params_ff [`TCC_NUM_WORDS];
  logic signed [15:0] setpoint, hyst, upper, lower, offs, tgt, temp;
  logic [7:0] fault_on, fault_off, start_dly, off_hold, interval, pwr_dly, passcode;
  logic polarity, card_wr;
  logic [4:0] card_wr_idx;
  logic [15:0] card_wr_data;

  assign setpoint  = params_ff[`TCC_IDX_SETPOINT];
  assign hyst      = params_ff[`TCC_IDX_HYST];
  assign upper     = params_ff[`TCC_IDX_UPPER];
  assign lower     = params_ff[`TCC_IDX_LOWER];
  assign offs      = params_ff[`TCC_IDX_OFFSET];
  assign polarity  = params_ff[`TCC_IDX_POLARITY][0];
  assign fault_on  = params_ff[`TCC_IDX_FAULT_ON][7:0];
  assign fault_off = params_ff[`TCC_IDX_FAULT_OFF][7:0];
  assign start_dly = params_ff[`TCC_IDX_START_DLY][7:0];
  assign off_hold  = params_ff[`TCC_IDX_OFF_HOLD][7:0];
  assign interval  = params_ff[`TCC_IDX_INTERVAL][7:0];
  assign pwr_dly   = params_ff[`TCC_IDX_PWR_DLY][7:0];
  assign passcode  = params_ff[`TCC_IDX_PASSCODE][7:0];

  // Limit and range checks per word
  function automatic logic [15:0] fit(input logic [4:0] i, input logic [15:0] v,
                                      input logic signed [15:0] lo, input logic signed [15:0] hi);
    logic signed [15:0] s;
    logic [15:0] r;
    s = v;
    r = v;
    case (i)
      `TCC_IDX_SETPOINT: r = (s > hi) ? hi : ((s < lo) ? lo : s);
      `TCC_IDX_UPPER:    r = (s > `TCC_MAX_UPPER) ? `TCC_MAX_UPPER : s;
      `TCC_IDX_LOWER:    r = (s < `TCC_MIN_LOWER) ? `TCC_MIN_LOWER : s;
      `TCC_IDX_OFFSET:   r = (s > `TCC_MAX_OFFSET) ? `TCC_MAX_OFFSET :
                             ((s < `TCC_MIN_OFFSET) ? `TCC_MIN_OFFSET : s);
      `TCC_IDX_FAULT_ON, `TCC_IDX_FAULT_OFF, `TCC_IDX_START_DLY, `TCC_IDX_OFF_HOLD,
      `TCC_IDX_INTERVAL, `TCC_IDX_PWR_DLY, `TCC_IDX_PASSCODE:
        r = (v > 16'(`TCC_MAX_TIME)) ? 16'(`TCC_MAX_TIME) : v;
      `TCC_IDX_PROBE:    r = (v > 16'h0002) ? 16'(`TCC_RST_PROBE) : v;
      default:           r = v;
    endcase
    return r;
  endfunction

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      for (int i = 0; i < `TCC_NUM_WORDS; i++) begin
        params_ff[i] <= 16'h0000;
      end
      params_ff[`TCC_IDX_HYST]      <= `TCC_RST_HYST;
      params_ff[`TCC_IDX_UPPER]     <= `TCC_RST_UPPER;
      params_ff[`TCC_IDX_LOWER]     <= `TCC_RST_LOWER;
      params_ff[`TCC_IDX_FAULT_OFF] <= 16'(`TCC_RST_FAULT_OFF);
      params_ff[`TCC_IDX_DECPOINT]  <= 16'h0001;
      params_ff[`TCC_IDX_PROBE]     <= 16'(`TCC_RST_PROBE);
      params_ff[`TCC_IDX_TABLE_ID]  <= `TCC_TABLE_ID;
    end else if (card_wr && card_wr_idx != 5'(`TCC_IDX_TABLE_ID)) begin
      params_ff[card_wr_idx] <= fit(card_wr_idx, card_wr_data, lower, upper);
    end else if (PARAM_WE && PARAM_IDX < 5'(`TCC_IDX_TABLE_ID)) begin
      params_ff[PARAM_IDX] <= fit(PARAM_IDX, PARAM_WDATA, lower, upper);
    end else if (BASIC_SET_WE && !params_ff[`TCC_IDX_GUARD][0]) begin
      params_ff[`TCC_IDX_SETPOINT] <= fit(5'(`TCC_IDX_SETPOINT), BASIC_SET_DATA, lower, upper);
    end
  end

  assign tgt = (setpoint > upper) ? upper : ((setpoint < lower) ? lower : setpoint);
  assign temp = PROBE_RAW + offs;

  // Timebase: second and minute enables
  logic [31:0] sec_cnt_ff;
  logic [7:0]  min_cnt_ff;
  logic        sec_tick_ff, min_tick_ff;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      sec_cnt_ff  <= 32'h0;
      min_cnt_ff  <= 8'h0;
      sec_tick_ff <= 1'b0;
      min_tick_ff <= 1'b0;
    end else begin
      sec_tick_ff <= 1'b0;
      min_tick_ff <= 1'b0;
      if (sec_cnt_ff == 32'(CYC_PER_SEC - 1)) begin
        sec_cnt_ff  <= 32'h0;
        sec_tick_ff <= 1'b1;
        if (min_cnt_ff == 8'(SEC_PER_MIN - 1)) begin
          min_cnt_ff  <= 8'h0;
          min_tick_ff <= 1'b1;
        end else begin
          min_cnt_ff <= min_cnt_ff + 8'h1;
        end
      end else begin
        sec_cnt_ff <= sec_cnt_ff + 32'h1;
      end
    end
  end

  logic demand_ff;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      demand_ff <= 1'b0;
    end else if (!polarity) begin
      if (temp > tgt + hyst) demand_ff <= 1'b1;
      else if (temp <= tgt) demand_ff <= 1'b0;
    end else begin
      if (temp < tgt - hyst) demand_ff <= 1'b1;
      else if (temp >= tgt) demand_ff <= 1'b0;
    end
  end

  logic       fault_phase_ff;
  logic [7:0] fault_cnt_ff;
  logic       fault_req;
  always_ff @(posedge REF_CLK) begin
    if (RST || !PROBE_FAULT) begin
      fault_phase_ff <= 1'b1;
      fault_cnt_ff   <= 8'h0;
    end else if (min_tick_ff) begin
      if (fault_cnt_ff + 8'h1 >= (fault_phase_ff ? fault_on : fault_off)) begin
        fault_cnt_ff   <= 8'h0;
        fault_phase_ff <= !fault_phase_ff;
      end else begin
        fault_cnt_ff <= fault_cnt_ff + 8'h1;
      end
    end
  end
  assign fault_req = (fault_on != 8'h0) &&
                     ((fault_off == 8'h0) || fault_phase_ff);

  logic want;
  assign want = PROBE_FAULT ? fault_req : demand_ff;

  logic [7:0] pwr_cnt_ff;
  logic       pwr_done;
  always_ff @(posedge REF_CLK) begin
    if (RST) pwr_cnt_ff <= 8'h0;
    else if (min_tick_ff && pwr_cnt_ff < pwr_dly) pwr_cnt_ff <= pwr_cnt_ff + 8'h1;
  end
  assign pwr_done = (pwr_cnt_ff >= pwr_dly);

  logic [7:0] start_cnt_ff;
  always_ff @(posedge REF_CLK) begin
    if (RST || !want || RELAY_OUT) start_cnt_ff <= 8'h0;
    else if (sec_tick_ff && start_cnt_ff < start_dly) start_cnt_ff <= start_cnt_ff + 8'h1;
  end

  logic [7:0] off_cnt_ff, gap_cnt_ff;
  logic       started_ff, nxt_relay;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      off_cnt_ff <= 8'hFF;
      gap_cnt_ff <= 8'hFF;
      started_ff <= 1'b0;
    end else begin
      if (RELAY_OUT) off_cnt_ff <= 8'h0;
      else if (min_tick_ff && off_cnt_ff != 8'hFF) off_cnt_ff <= off_cnt_ff + 8'h1;
      if (!RELAY_OUT && nxt_relay) begin
        gap_cnt_ff <= 8'h0;
        started_ff <= 1'b1;
      end else if (min_tick_ff && gap_cnt_ff != 8'hFF) begin
        gap_cnt_ff <= gap_cnt_ff + 8'h1;
      end
    end
  end

  assign nxt_relay = want && pwr_done &&
                     (RELAY_OUT || ((start_cnt_ff >= start_dly) &&
                                    (off_cnt_ff >= off_hold) &&
                                    (!started_ff || gap_cnt_ff >= interval)));
  always_ff @(posedge REF_CLK) begin
    if (RST) RELAY_OUT <= 1'b0;
    else RELAY_OUT <= nxt_relay;
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      USER_ACCESS_OK  <= 1'b0;
      TEMP_CORRECTED  <= 16'sh0000;
      SHOW_DECIMAL    <= 1'b1;
      SHOW_FAHRENHEIT <= 1'b0;
      PROBE_TYPE      <= `TCC_RST_PROBE;
    end else begin
      USER_ACCESS_OK  <= (passcode == 8'h0) || (PASSCODE_ENTRY == passcode);
      TEMP_CORRECTED  <= temp;
      SHOW_DECIMAL    <= params_ff[`TCC_IDX_DECPOINT][0];
      SHOW_FAHRENHEIT <= params_ff[`TCC_IDX_UNIT][0];
      PROBE_TYPE      <= params_ff[`TCC_IDX_PROBE][1:0];
    end
  end

  // Two-entry response buffer, ready only when empty, so one response held at a time
  tcc_pkg::tcc_card_rsp_t rbuf_ff [2];
  logic [1:0] rcnt_ff;
  logic       rptr_ff, wptr_ff, rpop;
  tcc_pkg::tcc_card_rsp_t rhead;
  assign rhead = rbuf_ff[rptr_ff];
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rcnt_ff        <= 2'h0;
      rptr_ff        <= 1'b0;
      wptr_ff        <= 1'b0;
      CARD_RSP_READY <= 1'b0;
    end else begin
      if (CARD_RSP_VALID && CARD_RSP_READY) begin
        rbuf_ff[wptr_ff] <= CARD_RSP;
        wptr_ff <= !wptr_ff;
      end
      if (rpop) rptr_ff <= !rptr_ff;
      rcnt_ff <= rcnt_ff + 2'((CARD_RSP_VALID && CARD_RSP_READY)) - 2'(rpop);
      CARD_RSP_READY <= (rcnt_ff + 2'((CARD_RSP_VALID && CARD_RSP_READY)) - 2'(rpop)) == 2'h0;
    end
  end

  tcc_pkg::tcc_card_state_t state_ff, ret_ff;
  logic [4:0] idx_ff;
  logic       okall_ff, pup_ff;
  assign rpop        = (state_ff == tcc_pkg::TCC_CS_WAIT) && (rcnt_ff != 2'h0);
  assign card_wr     = rpop && (ret_ff == tcc_pkg::TCC_CS_LOAD) && rhead.ok;
  assign card_wr_idx = idx_ff;
  assign card_wr_data = rhead.data;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_ff       <= tcc_pkg::TCC_CS_IDLE;
      ret_ff         <= tcc_pkg::TCC_CS_IDLE;
      idx_ff         <= 5'h0;
      okall_ff       <= 1'b1;
      pup_ff         <= 1'b1;
      CARD_REQ       <= '0;
      CARD_REQ_VALID <= 1'b0;
      CARD_SHOW      <= `TCC_SHOW_NONE;
      CARD_BUSY      <= 1'b0;
    end else begin
      case (state_ff)
        tcc_pkg::TCC_CS_IDLE: begin
          idx_ff   <= 5'h0;
          okall_ff <= 1'b1;
          pup_ff   <= 1'b0;
          if (pup_ff && CARD_PRESENT) begin
            state_ff <= tcc_pkg::TCC_CS_LOAD;
            CARD_BUSY <= 1'b1;
          end else if (CARD_ERASE && CARD_PRESENT) begin
            state_ff <= tcc_pkg::TCC_CS_ERASE;
            CARD_BUSY <= 1'b1;
          end else if (CARD_UPLOAD) begin
            state_ff  <= CARD_PRESENT ? tcc_pkg::TCC_CS_UP : tcc_pkg::TCC_CS_DONE;
            ret_ff    <= tcc_pkg::TCC_CS_UP;
            CARD_BUSY <= 1'b1;
          end
        end
        tcc_pkg::TCC_CS_LOAD, tcc_pkg::TCC_CS_UP, tcc_pkg::TCC_CS_ERASE: begin
          CARD_REQ.cmd  <= (state_ff == tcc_pkg::TCC_CS_LOAD) ? `TCC_CMD_READ :
                           (state_ff == tcc_pkg::TCC_CS_UP) ? `TCC_CMD_WRITE : `TCC_CMD_ERASE;
          CARD_REQ.idx  <= idx_ff;
          CARD_REQ.data <= params_ff[idx_ff];
          CARD_REQ_VALID <= 1'b1;
          ret_ff   <= state_ff;
          state_ff <= tcc_pkg::TCC_CS_WAIT;
        end
        tcc_pkg::TCC_CS_WAIT: begin
          if (CARD_REQ_VALID && CARD_REQ_READY) CARD_REQ_VALID <= 1'b0;
          if (rpop) begin
            okall_ff <= okall_ff && rhead.ok;
            if (ret_ff == tcc_pkg::TCC_CS_ERASE ||
                idx_ff == 5'(`TCC_NUM_WORDS - 1) || !CARD_PRESENT) begin
              state_ff <= tcc_pkg::TCC_CS_DONE;
            end else begin
              idx_ff   <= idx_ff + 5'h1;
              state_ff <= ret_ff;
            end
          end
        end
        tcc_pkg::TCC_CS_DONE: begin
          CARD_BUSY <= 1'b0;
          if (ret_ff == tcc_pkg::TCC_CS_LOAD)
            CARD_SHOW <= (okall_ff && CARD_PRESENT) ? `TCC_SHOW_DL_OK : `TCC_SHOW_DL_FAIL;
          else
            CARD_SHOW <= (okall_ff && CARD_PRESENT) ? `TCC_SHOW_YES : `TCC_SHOW_NO;
          state_ff <= tcc_pkg::TCC_CS_IDLE;
        end
        default: state_ff <= tcc_pkg::TCC_CS_IDLE;
      endcase
    end
  end

  // relay start needs power-up, start-delay and off-hold timers expired
  chk_relay_start_gates: assert property (@(posedge REF_CLK) disable iff (RST)
    $rose(RELAY_OUT) |-> $past(pwr_done) && $past(start_cnt_ff >= start_dly))
    else $error("relay started before timers expired");
  chk_off_hold_kept: assert property (@(posedge REF_CLK) disable iff (RST)
    $rose(RELAY_OUT) |-> $past(off_cnt_ff) >= $past(off_hold))
    else $error("relay restarted inside off hold");
  // relay is on only if want (demand, or fault cycle when faulty) was set
  chk_relay_needs_want: assert property (@(posedge REF_CLK) disable iff (RST)
    RELAY_OUT |-> $past(want))
    else $error("relay on without request");
  chk_fault_off_held: assert property (@(posedge REF_CLK) disable iff (RST)
    PROBE_FAULT && fault_on == 8'h0 ##1 PROBE_FAULT |-> !RELAY_OUT)
    else $error("relay on with zero fault on-time");
  chk_table_id_fixed: assert property (@(posedge REF_CLK) disable iff (RST)
    params_ff[`TCC_IDX_TABLE_ID] == `TCC_TABLE_ID)
    else $error("table id changed");
  chk_setpoint_clamped: assert property (@(posedge REF_CLK) disable iff (RST)
    PARAM_WE && PARAM_IDX == 5'(`TCC_IDX_SETPOINT) && !card_wr |=>
      $signed(params_ff[`TCC_IDX_SETPOINT]) <= $past(upper))
    else $error("setpoint above upper limit");
  chk_guard_blocks_set: assert property (@(posedge REF_CLK) disable iff (RST)
    BASIC_SET_WE && !PARAM_WE && !card_wr && params_ff[`TCC_IDX_GUARD][0] |=>
      $stable(params_ff[`TCC_IDX_SETPOINT]))
    else $error("setpoint changed under edit guard");
  chk_passcode_gate: assert property (@(posedge REF_CLK) disable iff (RST)
    passcode != 8'h0 && PASSCODE_ENTRY != passcode ##1 $stable(passcode) |-> !USER_ACCESS_OK)
    else $error("access granted with wrong passcode");
endmodule // tcc_thermostat

// ===== core/tcc_defs.svh
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH
// Timing
`define TCC_CLK_HZ        50000000
`define TCC_SEC_NS        1000000000
`define TCC_CYC_PER_SEC   (`TCC_SEC_NS / (`TCC_SEC_NS / `TCC_CLK_HZ))
`define TCC_SEC_PER_MIN   60
// Parameter map: word index
`define TCC_IDX_SETPOINT  0
`define TCC_IDX_HYST      1
`define TCC_IDX_UPPER     2
`define TCC_IDX_LOWER     3
`define TCC_IDX_POLARITY  4
`define TCC_IDX_FAULT_ON  5
`define TCC_IDX_FAULT_OFF 6
`define TCC_IDX_START_DLY 7
`define TCC_IDX_OFF_HOLD  8
`define TCC_IDX_INTERVAL  9
`define TCC_IDX_PWR_DLY   10
`define TCC_IDX_GUARD     11
`define TCC_IDX_PASSCODE  12
`define TCC_IDX_DECPOINT  13
`define TCC_IDX_OFFSET    14
`define TCC_IDX_UNIT      15
`define TCC_IDX_PROBE     16
`define TCC_IDX_TABLE_ID  17
`define TCC_NUM_WORDS     18
// Defaults and limits, tenths of a degree where temperature
`define TCC_RST_SETPOINT  16'sh0000
`define TCC_RST_HYST      16'sh0014
`define TCC_RST_UPPER     16'sh0578
`define TCC_RST_LOWER     16'shFDDA
`define TCC_MAX_UPPER     16'sh0BCC
`define TCC_MIN_LOWER     16'shFDBC
`define TCC_MAX_OFFSET    16'sh0078
`define TCC_MIN_OFFSET    16'shFF88
`define TCC_MAX_TIME      8'hFA
`define TCC_RST_FAULT_OFF 8'h01
`define TCC_RST_PROBE     2'h1
`define TCC_TABLE_ID      16'h0001
// Card status display codes
`define TCC_SHOW_NONE     3'h0
`define TCC_SHOW_YES      3'h1
`define TCC_SHOW_NO       3'h2
`define TCC_SHOW_DL_OK    3'h3
`define TCC_SHOW_DL_FAIL  3'h4
// Card link commands
`define TCC_CMD_READ      2'h0
`define TCC_CMD_WRITE     2'h1
`define TCC_CMD_ERASE     2'h2
`endif

// ===== core/tcc_pkg.sv
package tcc_pkg;
  typedef struct packed {
    logic [1:0]  cmd;
    logic [4:0]  idx;
    logic [15:0] data;
  } tcc_card_req_t;
  typedef struct packed {
    logic        ok;
    logic [15:0] data;
  } tcc_card_rsp_t;
  typedef enum logic [5:0] {
    TCC_CS_IDLE  = 6'h01,
    TCC_CS_LOAD  = 6'h02,
    TCC_CS_UP    = 6'h04,
    TCC_CS_ERASE = 6'h08,
    TCC_CS_WAIT  = 6'h10,
    TCC_CS_DONE  = 6'h20
  } tcc_card_state_t;
endpackage

// ===== sim/tcc_card_model.sv
`include "tcc_defs.svh"
module tcc_card_model (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire tcc_pkg::tcc_card_req_t req,
  input  wire logic                   req_valid,
  output logic                        req_ready,
  output tcc_pkg::tcc_card_rsp_t      rsp,
  output logic                        rsp_valid,
  input  wire logic                   rsp_ready,
  input  wire logic [3:0]             stall
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:17];
  logic [15:0] rd_ff;
  logic        ok_ff;
  logic        pend_ff;
  logic        tgl_ff;
  logic [3:0]  cnt_ff;
  initial begin
    for (int i = 0; i < 18; i++) mem[i] = 16'h0000;
    mem[1] = 16'h0014;
    mem[2] = 16'h0578;
    mem[3] = 16'hFDDA;
    mem[6] = 16'h0001;
    mem[15] = 16'h0001;
    mem[16] = 16'h0002;
    mem[17] = 16'h0001;
  end
  assign req_ready = !pend_ff;
  assign rsp = rsp_valid ? {ok_ff, rd_ff} : {tgl_ff, ~rd_ff};
  always @(posedge clk) begin
    if (rst) begin
      pend_ff <= 1'b0;
      rsp_valid <= 1'b0;
      tgl_ff <= 1'b0;
    end else begin
      tgl_ff <= !tgl_ff;
      if (req_valid && req_ready) begin
        pend_ff <= 1'b1;
        cnt_ff <= stall;
        ok_ff <= (req.idx <= 5'h11);
        if (req.idx <= 5'h11) begin
          case (req.cmd)
            `TCC_CMD_READ: rd_ff <= mem[req.idx];
            `TCC_CMD_WRITE: mem[req.idx] <= req.data;
            default: for (int i = 0; i < 18; i++) mem[i] <= 16'h0000;
          endcase
        end
      end else if (rsp_valid && rsp_ready) begin
        rsp_valid <= 1'b0;
        pend_ff <= 1'b0;
      end else if (pend_ff && !rsp_valid) begin
        if (cnt_ff == 4'h0) rsp_valid <= 1'b1;
        else cnt_ff <= cnt_ff - 4'h1;
      end
    end
  end
endmodule // tcc_card_model

// ===== sim/tb.sv
`include "tcc_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clk, rst, pfault, pwe, bwe, present, upl, ers;
  logic                   creq_v, creq_r, crsp_v, crsp_r, relay, uacc, sdec, sfah, busy;
  logic signed [15:0]     praw, bdata, tcorr;
  logic [4:0]             pidx;
  logic [15:0]            pwd;
  logic [7:0]             pcode;
  logic [3:0]             stall;
  logic [1:0]             ptype;
  logic [2:0]             cshow;
  tcc_pkg::tcc_card_req_t creq;
  tcc_pkg::tcc_card_rsp_t crsp;
  int                     n_fail = 0;
  int                     checks_done = 0;
  int                     cyc = 0;
  tcc_thermostat #(.CYC_PER_SEC(10), .SEC_PER_MIN(2)) tcc_thermostat_inst (
    .REF_CLK(clk), .RST(rst), .PROBE_RAW(praw), .PROBE_FAULT(pfault), .PARAM_WE(pwe),
    .PARAM_IDX(pidx), .PARAM_WDATA(pwd), .BASIC_SET_WE(bwe), .BASIC_SET_DATA(bdata),
    .PASSCODE_ENTRY(pcode), .CARD_PRESENT(present), .CARD_UPLOAD(upl), .CARD_ERASE(ers),
    .CARD_REQ(creq), .CARD_REQ_VALID(creq_v), .CARD_REQ_READY(creq_r), .CARD_RSP(crsp),
    .CARD_RSP_VALID(crsp_v), .CARD_RSP_READY(crsp_r), .RELAY_OUT(relay),
    .USER_ACCESS_OK(uacc), .TEMP_CORRECTED(tcorr), .SHOW_DECIMAL(sdec),
    .SHOW_FAHRENHEIT(sfah), .PROBE_TYPE(ptype), .CARD_SHOW(cshow), .CARD_BUSY(busy));
  tcc_card_model tcc_card_model_inst (
    .clk(clk), .rst(rst), .req(creq), .req_valid(creq_v), .req_ready(creq_r), .rsp(crsp),
    .rsp_valid(crsp_v), .rsp_ready(crsp_r), .stall(stall));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      $display("[FAIL] t=%0t timeout %h %h", $time, cyc, 6000);
      end_of_test;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wp(input logic [4:0] i, input logic [15:0] d);
    @(posedge clk);
    pwe <= 1'b1;
    pidx <= i;
    pwd <= d;
    @(posedge clk);
    pwe <= 1'b0;
  endtask
  task automatic bset(input logic [15:0] d);
    @(posedge clk);
    bwe <= 1'b1;
    bdata <= d;
    @(posedge clk);
    bwe <= 1'b0;
  endtask
  task automatic wait_idle;
    int k;
    k = 0;
    tick(3);
    while (busy !== 1'b0 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 3000) begin
      n_fail++;
      $display("[FAIL] t=%0t busy stuck %h %h", $time, k, 3000);
    end
  endtask
  task automatic card(input logic up);
    @(posedge clk);
    if (up) upl <= 1'b1;
    else ers <= 1'b1;
    @(posedge clk);
    upl <= 1'b0;
    ers <= 1'b0;
    wait_idle;
  endtask
  task automatic rchk(input int n, input logic e);
    tick(n);
    chk({15'h0000, relay}, {15'h0000, e});
  endtask
  task automatic probe(input logic [15:0] v, input int n, input logic e);
    @(posedge clk);
    praw <= v;
    rchk(n, e);
  endtask
  initial begin
    rst = 1'b1; pfault = 1'b0; pwe = 1'b0; bwe = 1'b0; present = 1'b1; upl = 1'b0;
    ers = 1'b0; praw = 16'h0000; bdata = 16'h0000; pidx = 5'h00; pwd = 16'h0000;
    pcode = 8'h00; stall = 4'h2;
    tick(9);
    chk(sdec, 16'h0001);
    chk(ptype, 16'h0001);
    tick(1);
    rst <= 1'b0;
    wait_idle;
    chk(cshow, `TCC_SHOW_DL_OK);
    chk(ptype, 16'h0002);
    chk(sdec, 16'h0000);
    chk(sfah, 16'h0001);
    $display("test load done");
    wp(5'h0E, 16'h0014);
    @(posedge clk);
    praw <= 16'h0064;
    tick(3);
    chk(tcorr, 16'h0078);
    wp(5'h0E, 16'hFF88);
    tick(3);
    chk(tcorr, 16'hFFEC);
    wp(5'h0E, 16'h0000);
    probe(16'h0000, 3, 1'b0);
    $display("test offset done");
    wp(5'h07, 16'h0003);
    probe(16'h0015, 20, 1'b0);
    rchk(20, 1'b1);
    probe(16'h0000, 5, 1'b0);
    wp(5'h07, 16'h0000);
    probe(16'h0014, 5, 1'b0);
    probe(16'h0015, 5, 1'b1);
    probe(16'h000A, 5, 1'b1);
    probe(16'h0000, 5, 1'b0);
    wp(5'h08, 16'h0002);
    probe(16'h0015, 10, 1'b0);
    rchk(30, 1'b1);
    wp(5'h08, 16'h0000);
    wp(5'h09, 16'h0003);
    probe(16'h0000, 5, 1'b0);
    probe(16'h0015, 5, 1'b0);
    rchk(60, 1'b1);
    wp(5'h09, 16'h0000);
    probe(16'h0000, 5, 1'b0);
    wp(5'h0A, 16'h0002);
    probe(16'h0015, 5, 1'b0);
    rchk(60, 1'b1);
    wp(5'h04, 16'h0001);
    probe(16'hFFEC, 5, 1'b0);
    probe(16'hFFEB, 5, 1'b1);
    probe(16'h0000, 5, 1'b0);
    wp(5'h04, 16'h0000);
    $display("test relay done");
    wp(5'h05, 16'h0001);
    wp(5'h06, 16'h0001);
    @(posedge clk);
    while (tcc_thermostat_inst.min_tick_ff !== 1'b1) begin
      @(posedge clk);
    end
    pfault <= 1'b1;
    rchk(10, 1'b1);
    rchk(20, 1'b0);
    rchk(20, 1'b1);
    wp(5'h05, 16'h0000);
    rchk(30, 1'b0);
    rchk(30, 1'b0);
    wp(5'h05, 16'h0001);
    wp(5'h06, 16'h0000);
    rchk(30, 1'b1);
    rchk(30, 1'b1);
    @(posedge clk);
    pfault <= 1'b0;
    $display("test fault done");
    chk(uacc, 16'h0001);
    wp(5'h0C, 16'h0007);
    tick(2);
    chk(uacc, 16'h0000);
    @(posedge clk);
    pcode <= 8'h07;
    tick(2);
    chk(uacc, 16'h0001);
    $display("test passcode done");
    stall <= 4'h3;
    wp(5'h11, 16'h5555);
    wp(5'h02, 16'h00C8);
    wp(5'h00, 16'h03E8);
    bset(16'h01F4);
    wp(5'h0B, 16'h0001);
    bset(16'h0096);
    wp(5'h0F, 16'h0000);
    card(1'b1);
    chk(cshow, `TCC_SHOW_YES);
    chk(tcc_card_model_inst.mem[0], 16'h00C8);
    chk(tcc_card_model_inst.mem[17], `TCC_TABLE_ID);
    chk(tcc_card_model_inst.mem[12], 16'h0007);
    $display("test upload done");
    card(1'b0);
    chk(tcc_card_model_inst.mem[0], 16'h0000);
    chk(tcc_card_model_inst.mem[17], 16'h0000);
    $display("test erase done");
    @(posedge clk);
    present <= 1'b0;
    card(1'b1);
    chk(cshow, `TCC_SHOW_NO);
    chk(tcc_card_model_inst.mem[0], 16'h0000);
    present <= 1'b1;
    $display("test absent card done");
    @(posedge clk);
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(20);
    present <= 1'b0;
    wait_idle;
    chk(cshow, `TCC_SHOW_DL_FAIL);
    $display("test load fail done");
    end_of_test;
  end
endmodule // tb
